// [src/pgt_timer.sv]
// Power gating interval timer core
`timescale 1ns/1ns
// Functional notes
// - Timer mode repeats gate pulses every interval
// - Gate low interval minus 50 ms, then high
// - Gate rests high during measurement
// - Pulse starts at interval start
// - Acknowledge taken on rising edge only
// - Only first acknowledge per interval acts
// - Valid acknowledge drives gate high
// - Manual request ignored while gate low; here it clears the pulse counters, stretching the pulse
// - Measure once, then enter selected mode
// - Measurement bounded to 120 ms
// - One-shot: single pulse after start-up
// - One-shot: manual request gives one pulse
// - Manual during measurement restarts measurement
// - Manual valid if high 20 of 30 ms
// - Manual input debounced on both edges
// - Gate low within 10 ms of manual; here only when a 30 ms debounce window closes with 20 ms high
// - Manual clears counters until input low
// - Manual held high: gate low, ack ignored
// - Interval measured falling edge to falling edge
// - Interval range 100 ms to 7200 s; only the 100 ms floor is clamped, no upper limit
module pgt_timer #(
    parameter int unsigned MEASURE_MAX_CYC = pgt_pkg::MEASURE_MAX_CYC,
    parameter int unsigned CYC_PER_MS      = pgt_pkg::CYC_PER_MS,
    parameter int unsigned OFF_GAP_CYC     = pgt_pkg::OFF_GAP_CYC,
    parameter int unsigned MANUAL_MIN_CYC  = pgt_pkg::MANUAL_MIN_CYC,
    parameter int unsigned MANUAL_WIN_CYC  = pgt_pkg::MANUAL_WINDOW_CYC
) (
    input  wire logic                 i_clk_sys,
    input  wire logic                 i_rst,
    input  wire logic                 i_mode_timer,
    input  wire logic                 i_ack,
    input  wire logic                 i_manual_on_level,
    input  wire pgt_pkg::pgt_measure_t i_measure,
    output logic                      o_measure_run,
    output logic                      o_measure_timeout,
    output logic                      o_gate_drive_n
);
    pgt_pkg::pgt_state_t state;
    pgt_pkg::pgt_state_t next_state;
    logic [pgt_pkg::INTERVAL_W-1:0] interval_ms;
    logic [pgt_pkg::INTERVAL_W-1:0] next_interval_ms;
    logic [pgt_pkg::INTERVAL_W-1:0] ms_cnt;
    logic [pgt_pkg::INTERVAL_W-1:0] next_ms_cnt;
    logic [31:0] sub_cnt;
    logic [31:0] next_sub_cnt;
    logic [31:0] meas_cnt;
    logic [31:0] next_meas_cnt;
    logic        ack_prev;
    logic        ack_used;
    logic        next_ack_used;
    logic        gate_n;
    logic        next_gate_n;
    logic        timeout;
    logic        next_timeout;
    logic        manual;
    logic        ack_rise;
    logic        ms_tick;
    logic        in_service;
    logic [pgt_pkg::INTERVAL_W-1:0] on_ms;
    logic [31:0] gap_cyc;
    logic [31:0] next_gap_cyc;

    pgt_debounce #(
        .MIN_CYC    (MANUAL_MIN_CYC),
        .WINDOW_CYC (MANUAL_WIN_CYC)
    ) u_debounce (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_enable  (in_service),
        .i_level   (i_manual_on_level),
        .o_level   (manual)
    );

    assign in_service = (state != pgt_pkg::PGT_MEASURE);
    assign ack_rise   = i_ack && !ack_prev;
    assign ms_tick    = (sub_cnt == 32'(CYC_PER_MS - 1));
    assign on_ms      = interval_ms - pgt_pkg::INTERVAL_W'(pgt_pkg::OFF_GAP_MS);

    always_comb begin
        next_state       = state;
        next_interval_ms = interval_ms;
        next_ms_cnt      = ms_cnt;
        next_sub_cnt     = ms_tick ? 32'h0 : sub_cnt + 32'h1;
        next_meas_cnt    = meas_cnt;
        next_ack_used    = ack_used;
        next_gate_n      = gate_n;
        next_timeout     = timeout;
        case (state)
            pgt_pkg::PGT_MEASURE: begin
                next_gate_n   = 1'b1;
                next_meas_cnt = meas_cnt + 32'h1;
                if (i_manual_on_level) begin
                    next_meas_cnt = 32'h0;
                end else if (i_measure.done
                             || meas_cnt >= 32'(MEASURE_MAX_CYC - 1)) begin
                    if (i_measure.done) begin
                        // Clamp up to the lower end of the usable range
                        if (i_measure.ms < pgt_pkg::INTERVAL_W'(pgt_pkg::INTERVAL_MIN_MS))
                            next_interval_ms = pgt_pkg::INTERVAL_W'(pgt_pkg::INTERVAL_MIN_MS);
                        else
                            next_interval_ms = i_measure.ms;
                    end else begin
                        next_timeout = 1'b1;
                    end
                    // Start first pulse in either mode
                    next_state    = pgt_pkg::PGT_ON;
                    next_gate_n   = 1'b0;
                    next_ms_cnt   = '0;
                    next_sub_cnt  = 32'h0;
                    next_meas_cnt = 32'h0;
                    next_ack_used = 1'b0;
                end
            end
            pgt_pkg::PGT_ON: begin
                if (ms_tick) next_ms_cnt = ms_cnt + 1'b1;
                if (manual) begin
                    // Clears counters; gate already low so no new pulse
                    next_ms_cnt  = '0;
                    next_sub_cnt = 32'h0;
                end else if (ack_rise && !ack_used) begin
                    next_ack_used = 1'b1;
                    next_gate_n   = 1'b1;
                    next_state    = i_mode_timer ? pgt_pkg::PGT_OFF_GAP
                                                 : pgt_pkg::PGT_IDLE;
                end else if (ms_tick && ms_cnt + 1'b1 >= on_ms) begin
                    next_gate_n = 1'b1;
                    next_state  = i_mode_timer ? pgt_pkg::PGT_OFF_GAP
                                               : pgt_pkg::PGT_IDLE;
                end
            end
            pgt_pkg::PGT_OFF_GAP: begin
                if (ms_tick) next_ms_cnt = ms_cnt + 1'b1;
                if (manual) begin
                    next_state  = pgt_pkg::PGT_MANUAL_HOLD;
                    next_gate_n = 1'b0;
                    next_ms_cnt = '0;
                end else if (!i_mode_timer) begin
                    next_state = pgt_pkg::PGT_IDLE;
                end else if (ms_tick && ms_cnt + 1'b1 >= interval_ms) begin
                    // Next interval opens with the gate falling edge
                    next_state    = pgt_pkg::PGT_ON;
                    next_gate_n   = 1'b0;
                    next_ms_cnt   = '0;
                    next_ack_used = 1'b0;
                end
            end
            pgt_pkg::PGT_IDLE: begin
                next_gate_n = 1'b1;
                next_ms_cnt = '0;
                if (manual) begin
                    next_state  = pgt_pkg::PGT_MANUAL_HOLD;
                    next_gate_n = 1'b0;
                end
            end
            pgt_pkg::PGT_MANUAL_HOLD: begin
                // Gate held low, counters cleared, acks ignored
                next_gate_n  = 1'b0;
                next_ms_cnt  = '0;
                next_sub_cnt = 32'h0;
                if (!manual) begin
                    next_state    = pgt_pkg::PGT_ON;
                    next_ack_used = 1'b0;
                end
            end
            default: begin
                next_state  = pgt_pkg::PGT_MEASURE;
                next_gate_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state       <= pgt_pkg::PGT_MEASURE;
            interval_ms <= pgt_pkg::INTERVAL_RST;
            ms_cnt      <= '0;
            sub_cnt     <= 32'h0;
            meas_cnt    <= 32'h0;
            ack_prev    <= 1'b0;
            ack_used    <= 1'b0;
            gate_n      <= 1'b1;
            timeout     <= 1'b0;
        end else begin
            state       <= next_state;
            interval_ms <= next_interval_ms;
            ms_cnt      <= next_ms_cnt;
            sub_cnt     <= next_sub_cnt;
            meas_cnt    <= next_meas_cnt;
            ack_prev    <= i_ack;
            ack_used    <= next_ack_used;
            gate_n      <= next_gate_n;
            timeout     <= next_timeout;
        end
    end

    assign o_gate_drive_n    = gate_n;
    assign o_measure_run     = (state == pgt_pkg::PGT_MEASURE);
    assign o_measure_timeout = timeout;

    // Cycles spent in the off gap, for the gap length check
    always_comb begin
        next_gap_cyc = (state == pgt_pkg::PGT_OFF_GAP) ? gap_cyc + 32'h1 : 32'h0;
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            gap_cyc <= 32'h0;
        end else begin
            gap_cyc <= next_gap_cyc;
        end
    end

    property p_ack_turns_off;
        @(posedge i_clk_sys) disable iff (i_rst)
        (state == pgt_pkg::PGT_ON && ack_rise && !ack_used && !manual) |=> gate_n;
    endproperty
    a_ack_turns_off: assert property (p_ack_turns_off)
        else $error("acknowledge did not raise gate");

    property p_ack_level_ignored;
        @(posedge i_clk_sys) disable iff (i_rst)
        (state == pgt_pkg::PGT_ON && i_ack && ack_prev && !manual && !ms_tick) |=> !gate_n;
    endproperty
    a_ack_level_ignored: assert property (p_ack_level_ignored)
        else $error("steady acknowledge level ended the pulse");

    property p_second_ack_ignored;
        @(posedge i_clk_sys) disable iff (i_rst)
        (state == pgt_pkg::PGT_OFF_GAP && ack_rise && !manual && !ms_tick) |=> gate_n;
    endproperty
    a_second_ack_ignored: assert property (p_second_ack_ignored)
        else $error("extra acknowledge changed the gate");

    property p_hold_ignores_ack;
        @(posedge i_clk_sys) disable iff (i_rst)
        (state == pgt_pkg::PGT_MANUAL_HOLD && manual) |=> !gate_n;
    endproperty
    a_hold_ignores_ack: assert property (p_hold_ignores_ack)
        else $error("gate rose during manual hold");

    property p_measure_gate_high;
        @(posedge i_clk_sys) disable iff (i_rst)
        (state == pgt_pkg::PGT_MEASURE) |-> gate_n;
    endproperty
    a_measure_gate_high: assert property (p_measure_gate_high)
        else $error("gate low during measurement");

    property p_measure_bound;
        @(posedge i_clk_sys) disable iff (i_rst)
        (meas_cnt < 32'(MEASURE_MAX_CYC));
    endproperty
    a_measure_bound: assert property (p_measure_bound)
        else $error("measurement ran past its bound");

    property p_manual_restarts_measure;
        @(posedge i_clk_sys) disable iff (i_rst)
        (state == pgt_pkg::PGT_MEASURE && i_manual_on_level)
        |=> (meas_cnt == 32'h0 && state == pgt_pkg::PGT_MEASURE);
    endproperty
    a_manual_restarts_measure: assert property (p_manual_restarts_measure)
        else $error("manual input did not restart measurement");

    property p_manual_drives_low;
        @(posedge i_clk_sys) disable iff (i_rst)
        (manual && (state == pgt_pkg::PGT_IDLE || state == pgt_pkg::PGT_OFF_GAP))
        |=> !gate_n ##1 !gate_n;
    endproperty
    a_manual_drives_low: assert property (p_manual_drives_low)
        else $error("manual request did not drive gate low");

    property p_pulse_starts_on;
        @(posedge i_clk_sys) disable iff (i_rst)
        $fell(gate_n) |-> (state == pgt_pkg::PGT_ON || state == pgt_pkg::PGT_MANUAL_HOLD)
                          && ms_cnt == '0;
    endproperty
    a_pulse_starts_on: assert property (p_pulse_starts_on)
        else $error("gate fell outside an interval start");

    property p_gap_before_next;
        @(posedge i_clk_sys) disable iff (i_rst)
        (state == pgt_pkg::PGT_OFF_GAP && next_state == pgt_pkg::PGT_ON)
        |-> gap_cyc >= 32'(OFF_GAP_CYC - 1);
    endproperty
    a_gap_before_next: assert property (p_gap_before_next)
        else $error("off gap shorter than its minimum");

    property p_manual_ignored_on;
        @(posedge i_clk_sys) disable iff (i_rst)
        (state == pgt_pkg::PGT_ON && manual)
        |=> (state == pgt_pkg::PGT_ON && !gate_n && ms_cnt == '0);
    endproperty
    a_manual_ignored_on: assert property (p_manual_ignored_on)
        else $error("manual request during pulse was not ignored");

    property p_timeout_starts;
        @(posedge i_clk_sys) disable iff (i_rst)
        (state == pgt_pkg::PGT_MEASURE && !i_manual_on_level && !i_measure.done
         && meas_cnt == 32'(MEASURE_MAX_CYC - 1))
        |=> (timeout && !gate_n && interval_ms == pgt_pkg::INTERVAL_RST);
    endproperty
    a_timeout_starts: assert property (p_timeout_starts)
        else $error("measurement bound did not start the default pulse");

    property p_idle_stays_off;
        @(posedge i_clk_sys) disable iff (i_rst)
        (state == pgt_pkg::PGT_IDLE && !manual) |=> gate_n;
    endproperty
    a_idle_stays_off: assert property (p_idle_stays_off)
        else $error("one-shot issued a pulse without a request");

    property p_interval_floor;
        @(posedge i_clk_sys) disable iff (i_rst)
        (state != pgt_pkg::PGT_MEASURE)
        |-> interval_ms >= pgt_pkg::INTERVAL_W'(pgt_pkg::INTERVAL_MIN_MS);
    endproperty
    a_interval_floor: assert property (p_interval_floor)
        else $error("interval below its minimum");
endmodule

// [src/pgt_pkg.sv]
// Shared constants and carrier types for the power gating interval timer
package pgt_pkg;
    localparam int unsigned CLK_HZ            = 20000000;
    localparam int unsigned CLK_PERIOD_NS     = 50;
    // Times in their printed units
    localparam int unsigned OFF_GAP_MS        = 50;
    localparam int unsigned ACK_MIN_WIDTH_NS  = 100;
    localparam int unsigned MEASURE_TYP_MS    = 100;
    localparam int unsigned MEASURE_MAX_MS    = 120;
    localparam int unsigned MANUAL_MIN_MS     = 20;
    localparam int unsigned MANUAL_WINDOW_MS  = 30;
    localparam int unsigned MANUAL_DRIVE_MS   = 10;
    localparam int unsigned INTERVAL_MIN_MS   = 100;
    localparam int unsigned INTERVAL_MAX_S    = 7200;
    // Cycle counts derived from the clock rate
    localparam int unsigned CYC_PER_MS        = CLK_HZ / 1000;
    localparam int unsigned OFF_GAP_CYC       = OFF_GAP_MS * CYC_PER_MS;
    localparam int unsigned MEASURE_MAX_CYC   = MEASURE_MAX_MS * CYC_PER_MS;
    localparam int unsigned MANUAL_MIN_CYC    = MANUAL_MIN_MS * CYC_PER_MS;
    localparam int unsigned MANUAL_WINDOW_CYC = MANUAL_WINDOW_MS * CYC_PER_MS;
    // Interval value is given in milliseconds
    localparam int unsigned INTERVAL_W        = 23;
    localparam logic [INTERVAL_W-1:0] INTERVAL_RST = 23'h000064;

    typedef enum {
        PGT_MEASURE,
        PGT_ON,
        PGT_OFF_GAP,
        PGT_IDLE,
        PGT_MANUAL_HOLD
    } pgt_state_t;

    typedef struct packed {
        logic                  done;
        logic [INTERVAL_W-1:0] ms;
    } pgt_measure_t;
endpackage

// [src/pgt_debounce.sv]
// Debouncer for the manual power-on level
`timescale 1ns/1ns
module pgt_debounce #(
    parameter int unsigned MIN_CYC    = pgt_pkg::MANUAL_MIN_CYC,
    parameter int unsigned WINDOW_CYC = pgt_pkg::MANUAL_WINDOW_CYC
) (
    input  wire logic i_clk_sys,
    input  wire logic i_rst,
    input  wire logic i_enable,
    input  wire logic i_level,
    output logic      o_level
);
    logic        sync1;
    logic        sync2;
    logic [31:0] win_cnt;
    logic [31:0] high_cnt;
    logic        level;
    logic        next_sync1;
    logic        next_sync2;
    logic [31:0] next_win_cnt;
    logic [31:0] next_high_cnt;
    logic        next_level;

    always_comb begin
        next_sync1    = i_level;
        next_sync2    = sync1;
        next_win_cnt  = win_cnt;
        next_high_cnt = high_cnt;
        next_level    = level;
        if (!i_enable) begin
            next_win_cnt  = 32'h0;
            next_high_cnt = 32'h0;
            next_level    = 1'b0;
        end else if (win_cnt >= WINDOW_CYC - 1) begin
            // Window closes: both edges judged over a full window
            next_level    = level ? (high_cnt + 32'(sync2) >= 32'(WINDOW_CYC - MIN_CYC))
                                  : (high_cnt + 32'(sync2) >= 32'(MIN_CYC));
            next_win_cnt  = 32'h0;
            next_high_cnt = 32'h0;
        end else begin
            next_win_cnt  = win_cnt + 32'h1;
            next_high_cnt = high_cnt + 32'(sync2);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            sync1    <= 1'b0;
            sync2    <= 1'b0;
            win_cnt  <= 32'h0;
            high_cnt <= 32'h0;
            level    <= 1'b0;
        end else begin
            sync1    <= next_sync1;
            sync2    <= next_sync2;
            win_cnt  <= next_win_cnt;
            high_cnt <= next_high_cnt;
            level    <= next_level;
        end
    end

    assign o_level = level;

    property p_short_glitch_no_detect;
        @(posedge i_clk_sys) disable iff (i_rst)
        (!level && win_cnt == 32'h0 && high_cnt == 32'h0 && !sync2)[*1] ##1 !sync2[*2]
        |-> !level;
    endproperty
    a_short_glitch_no_detect: assert property (p_short_glitch_no_detect)
        else $error("manual level rose without enough high time");
endmodule

// [bench/pgt_mcu_model.sv]
// Microcontroller model powered through the gated load switch
`timescale 1ns/1ns
module pgt_mcu_model (
    input  wire logic        i_clk_sys,
    input  wire logic        i_gate_drive_n,
    input  wire logic        i_ack_en,
    input  wire logic        i_ack_stuck,
    input  wire logic        i_ack_double,
    input  wire logic [15:0] i_ack_delay,
    output logic             o_ack
);
    int unsigned up_cyc = 0;
    logic        gate_q = 1'b1;
    logic        first;
    logic        second;

    // Cycles since the latest power-on edge
    always @(negedge i_clk_sys) begin
        gate_q <= i_gate_drive_n;
        if (gate_q && !i_gate_drive_n) begin
            up_cyc <= 0;
        end else begin
            up_cyc <= up_cyc + 1;
        end
    end

    // Pulses last 3 cycles, well above the minimum width
    always_comb begin
        first  = up_cyc >= i_ack_delay && up_cyc < i_ack_delay + 3;
        second = up_cyc >= i_ack_delay + 6 && up_cyc < i_ack_delay + 9;
        // Full width kept while power drops; a second pulse only on command
        o_ack  = i_ack_stuck | (i_ack_en && (first || (i_ack_double && second)));
    end
endmodule

// [bench/test_power_gating_interval_timer.sv]
// Self-checking testbench for the power gating interval timer
`timescale 1ns/1ns
module test_power_gating_interval_timer;
    localparam int CPM = 10;
    localparam int WIN = 30;

    logic                  clk_sys = 1'b0;
    logic                  rst     = 1'b1;
    logic                  mode    = 1'b1;
    logic                  manual  = 1'b0;
    pgt_pkg::pgt_measure_t measure = '0;
    logic                  ack_en  = 1'b0;
    logic                  stuck   = 1'b0;
    logic                  dbl     = 1'b0;
    logic [15:0]           delay   = 16'h0064;
    logic                  ack;
    logic                  run;
    logic                  tmo;
    logic                  gate_n;
    int                    mismatches = 0;
    int                    n_compared = 0;
    int                    n;
    int                    m;

    always #25 clk_sys = ~clk_sys;

    pgt_timer #(
        .MEASURE_MAX_CYC (120 * CPM),
        .CYC_PER_MS      (CPM),
        .OFF_GAP_CYC     (50 * CPM),
        .MANUAL_MIN_CYC  (20),
        .MANUAL_WIN_CYC  (WIN)
    ) dut_u (
        .i_clk_sys         (clk_sys),
        .i_rst             (rst),
        .i_mode_timer      (mode),
        .i_ack             (ack),
        .i_manual_on_level (manual),
        .i_measure         (measure),
        .o_measure_run     (run),
        .o_measure_timeout (tmo),
        .o_gate_drive_n    (gate_n)
    );

    pgt_mcu_model mcu_u (
        .i_clk_sys      (clk_sys),
        .i_gate_drive_n (gate_n),
        .i_ack_en       (ack_en),
        .i_ack_stuck    (stuck),
        .i_ack_double   (dbl),
        .i_ack_delay    (delay),
        .o_ack          (ack)
    );

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic in_range(input string name, input int v, input int lo, input int hi);
        check(name, 32'(v >= lo && v <= hi), 32'h1);
    endtask

    task automatic wait_gate(input logic lvl, input int lim, output int cnt);
        cnt = 0;
        while (gate_n !== lvl && cnt < lim) begin
            @(negedge clk_sys);
            cnt++;
        end
    endtask

    task automatic do_reset(input logic mode_v);
        rst  = 1'b1;
        mode = mode_v;
        repeat (3) @(negedge clk_sys);
        rst = 1'b0;
    endtask

    task automatic give_done(input logic [22:0] ms);
        measure = '{1'b1, ms};
        @(negedge clk_sys);
        measure = '0;
    endtask

    task automatic t_timer_plain;
        do_reset(1'b1);
        repeat (5) @(negedge clk_sys);
        check("run_measuring", run, 32'h1);
        check("gate_rest", gate_n, 32'h1);
        // Below the range, so the floor of 100 ms applies
        give_done(23'h000032);
        check("gate_start", gate_n, 32'h0);
        check("run_after", run, 32'h0);
        wait_gate(1'b1, 2000, n);
        check("low_len", n, 32'd500);
        wait_gate(1'b0, 2000, m);
        check("period", n + m, 32'd1000);
    endtask

    task automatic t_ack;
        ack_en = 1'b1;
        dbl    = 1'b1;
        wait_gate(1'b1, 2000, n);
        in_range("ack_off", n, 100, 104);
        wait_gate(1'b0, 2000, m);
        check("ack_period", n + m, 32'd1000);
        wait_gate(1'b1, 2000, n);
        ack_en = 1'b0;
        stuck  = 1'b1;
        wait_gate(1'b0, 2000, m);
        wait_gate(1'b1, 2000, n);
        check("level_ack", n, 32'd500);
        stuck = 1'b0;
        dbl   = 1'b0;
    endtask

    task automatic t_timeout;
        do_reset(1'b1);
        wait_gate(1'b0, 1400, n);
        in_range("tmo_start", n, 1198, 1204);
        check("tmo_flag", tmo, 32'h1);
        wait_gate(1'b1, 2000, n);
        check("tmo_low", n, 32'd500);
        // Manual request while the gate is low only stretches the pulse
        wait_gate(1'b0, 1000, n);
        manual = 1'b1;
        repeat (40) @(negedge clk_sys);
        manual = 1'b0;
        wait_gate(1'b1, 3000, n);
        in_range("on_extend", n, 500, 500 + 2 * WIN);
    endtask

    task automatic t_oneshot_manual;
        do_reset(1'b0);
        manual = 1'b1;
        repeat (50) @(negedge clk_sys);
        give_done(23'h000096);
        check("aborted", run, 32'h1);
        manual = 1'b0;
        repeat (10) @(negedge clk_sys);
        give_done(23'h000096);
        check("restart", gate_n, 32'h0);
        wait_gate(1'b1, 3000, n);
        check("one_low", n, 32'd1000);
        wait_gate(1'b0, 3000, n);
        check("no_repeat", n, 32'd3000);
        manual = 1'b1;
        repeat (5) @(negedge clk_sys);
        manual = 1'b0;
        wait_gate(1'b0, 200, n);
        check("glitch", n, 32'd200);
        manual = 1'b1;
        wait_gate(1'b0, 200, n);
        in_range("man_on", n, 20, 2 * WIN + 10);
        ack_en = 1'b1;
        delay  = 16'h0005;
        m      = 0;
        repeat (300) begin
            @(negedge clk_sys);
            m += gate_n;
        end
        check("held_on", m, 32'h0);
        ack_en = 1'b0;
        manual = 1'b0;
        wait_gate(1'b1, 3000, n);
        in_range("man_len", n, 1000, 1000 + 2 * WIN + 10);
        ack_en = 1'b1;
        delay  = 16'h00C8;
        manual = 1'b1;
        repeat (40) @(negedge clk_sys);
        manual = 1'b0;
        wait_gate(1'b0, 200, n);
        wait_gate(1'b1, 3000, n);
        in_range("man_ack", n, 195, 205);
        ack_en = 1'b0;
    endtask

    task automatic report_and_stop;
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #(50 * 60000);
        mismatches++;
        report_and_stop();
    end

    initial begin
        @(negedge clk_sys);
        t_timer_plain();
        t_ack();
        t_timeout();
        t_oneshot_manual();
        report_and_stop();
    end
endmodule
